// >>> design/usr_pkg.sv
// Package for the serial port status and holding register block.
// Assumes a single clock domain and a plain register port.
package usr_pkg;
    localparam logic [7:0] OFF_MASK_EN  = 8'h08;
    localparam logic [7:0] OFF_MASK_DIS = 8'h0c;
    localparam logic [7:0] OFF_MASK_RB  = 8'h10;
    localparam logic [7:0] OFF_STATUS   = 8'h14;
    localparam logic [7:0] OFF_RX_HOLD  = 8'h18;
    localparam logic [7:0] OFF_TX_HOLD  = 8'h1c;
    localparam logic [7:0] OFF_BAUD     = 8'h20;
    localparam logic [7:0] OFF_CTRL     = 8'h00;

    // Status bit positions, then the Manchester mask, transmit sync and baud fraction bits
    localparam int B_RX_CHAR_READY  = 0;
    localparam int B_TXFREE = 1;
    localparam int B_BRK    = 2;
    localparam int B_RX_DMA_END  = 3;
    localparam int B_TX_DMA_END  = 4;
    localparam int B_OVR    = 5;
    localparam int B_FRAME  = 6;
    localparam int B_PAR    = 7;
    localparam int B_TMO    = 8;
    localparam int B_TXEMP  = 9;
    localparam int B_RETRY_LIMIT_HIT   = 10;
    localparam int B_TX_DMA_BUFFER_EMPTY = 11;
    localparam int B_RX_DMA_BUFFER_FULL = 12;
    localparam int B_NEGATIVE_ACK_FLAG   = 13;
    localparam int B_RIC    = 16;
    localparam int B_CTSC   = 19;
    localparam int B_LVL    = 20;
    localparam int B_MANCHESTER_ERROR_FLAG = 24;
    localparam int B_MANMSK = 20;
    localparam int B_SYNC   = 15;
    localparam int B_FP_LO  = 16;

    // Command bits in the control register
    localparam int C_RXEN   = 0;
    localparam int C_RXDIS  = 1;
    localparam int C_TXEN   = 2;
    localparam int C_TXDIS  = 3;
    localparam int C_CLEAR_STATUS_CMD = 4;
    localparam int C_RSTNAK = 5;
    localparam int C_START_TIMEOUT_CMD  = 6;
    localparam int C_START_BREAK_CMD = 7;
    localparam int C_STPBRK = 8;

    localparam logic [31:0] MASK_VALID = 32'h001f_3fff;
    localparam logic [31:0] ZERO32     = 32'h0000_0000;
    localparam logic [15:0] DIV_RST    = 16'h0000;
    localparam logic [4:0]  OVERSAMPLE = 5'h10;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } usr_bus_t;

    typedef struct packed {
        logic rx_end;
        logic tx_end;
        logic tx_buf_empty;
        logic rx_buf_full;
    } usr_dma_t;

    // Events from the line logic, one-cycle pulses
    typedef struct packed {
        logic       char_done;
        logic [8:0] char_val;
        logic       char_cmd;
        logic       brk;
        logic       overrun;
        logic       frame;
        logic       parity;
        logic       timeout;
        logic       retry_limit_hit;
        logic       negative_ack_flag;
        logic       manchester_error_flag;
    } usr_rxev_t;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b001,
        TX_SHIFT = 3'b010,
        TX_BREAK = 3'b100
    } usr_tx_st_t;
endpackage : usr_pkg

// >>> design/usr_regs.sv
// Status, mask, holding and baud divider registers of the serial port.
// Assumes receive events arrive as synchronous pulses and that the
// shifter acknowledges each character with tx_shift_done.
// The baud fraction is kept for software but does not shape the tick.
// Function
// - Mask readback mirrors status bit positions, except the Manchester mask at bit 20
// - Receive ready set on char, cleared on read
// - Transmit free low while holding, break, disabled
// - Break seen sticky until status clear
// - Overrun sticky until status clear
// - Framing error sticky until status clear
// - Parity error sticky until status clear
// - Time-out flag after start, zero if disabled
// - All-empty needs holding and shifter empty
// - Retry limit sticky until status clear
// - Transfer channel flags are live copies
// - Negative ack cleared only by negative_ack_flag clear
// - Modem change flags cleared by status read
// - Manchester error sticky at bit 24
// - Receive holding gives char and command bit
// - Transmit bit 15 selects command sync
// - Next character queued behind current one
// - Baud register holds divisor and fraction
// - Enable sets, disable clears mask bits
// - Baud tick is clock over 16 and divisor
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module usr_regs
    import usr_pkg::*;
#(
    parameter int DIV_W = 16
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    // Register port
    input  wire usr_pkg::usr_bus_t bus,
    output logic [31:0]            rdata,
    // Line side
    input  wire usr_pkg::usr_rxev_t rx_ev,
    input  wire usr_pkg::usr_dma_t  dma,
    input  wire logic [3:0]        modem_in,
    input  wire logic              timeout_armed,
    input  wire logic              tx_shift_done,
    // Transmit shifter feed and interrupt
    output logic                   tx_load,
    output logic [8:0]             tx_char,
    output logic                   tx_cmd_sync,
    output logic                   tx_break,
    output logic                   baud_tick,
    output logic                   irq
);
    import usr_pkg::*;

    logic [31:0] mask_r;
    logic        rx_en_r, tx_en_r;
    logic        rx_char_ready_r, rx_pend_r;
    logic [8:0]  rx_char_r;
    logic        rx_cmd_r;
    logic        hold_full_r, brk_pend_r;
    usr_tx_st_t  tx_st_r;
    logic        brk_r, ovr_r, frm_r, par_r, tmo_r, retry_limit_hit_r, negative_ack_flag_r, man_r;
    logic [3:0]  mchg_r, mlvl_r;
    logic [15:0] div_r;
    logic [2:0]  fp_r;
    logic [DIV_W-1:0] div_cnt_r;
    logic [3:0]  os_cnt_r;
    logic [8:0]  hold_char_r;
    logic        hold_cmd_r;
    logic [31:0] status;
    logic        wr_ctrl, wr_thr, rd_csr, rd_rhr, rst_sta;

    // Address decode of one strobe
    function automatic logic hit(input logic s, input logic [7:0] off);
        hit = s && (bus.addr == off);
    endfunction : hit

    // Set wins over clear so an event in the clear cycle is not lost
    function automatic logic sticky(input logic ev, input logic flag,
                                    input logic clr);
        sticky = ev | (flag & ~clr);
    endfunction : sticky

    // One command bit of a control register write
    function automatic logic cmd(input int b);
        cmd = wr_ctrl && bus.wdata[b];
    endfunction : cmd

    assign wr_ctrl = hit(bus.wr, OFF_CTRL);
    assign wr_thr  = hit(bus.wr, OFF_TX_HOLD);
    assign rd_csr  = hit(bus.rd, OFF_STATUS);
    assign rd_rhr  = hit(bus.rd, OFF_RX_HOLD);
    assign rst_sta = cmd(C_CLEAR_STATUS_CMD);

    // Enable state of both directions
    // Disable wins over enable when both bits are written together
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rx_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end
        else if (clk_en && wr_ctrl)
        begin
            if (bus.wdata[C_RXDIS])
                rx_en_r <= 1'b0;
            else if (bus.wdata[C_RXEN])
                rx_en_r <= 1'b1;
            if (bus.wdata[C_TXDIS])
                tx_en_r <= 1'b0;
            else if (bus.wdata[C_TXEN])
                tx_en_r <= 1'b1;
        end
    end

    // Mask register
    // Bits outside the valid set never read back as one
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            mask_r <= ZERO32;
        else if (clk_en && hit(bus.wr, OFF_MASK_EN))
            mask_r <= mask_r | (bus.wdata & MASK_VALID);
        else if (clk_en && hit(bus.wr, OFF_MASK_DIS))
            mask_r <= mask_r & ~(bus.wdata & MASK_VALID);
    end

    // Receive holding; pend survives a disable so re-enable shows it
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rx_pend_r <= 1'b0;
            rx_char_r <= 9'h000;
            rx_cmd_r  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rx_ev.char_done)
            begin
                rx_pend_r <= 1'b1;
                rx_char_r <= rx_ev.char_val;
                rx_cmd_r  <= rx_ev.char_cmd;
            end
            // A read while disabled leaves the character pending
            else if (rd_rhr && rx_en_r)
                rx_pend_r <= 1'b0;
        end
    end
    assign rx_char_ready_r = rx_pend_r && rx_en_r;

    // Transmit holding and shifter occupancy
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            hold_full_r <= 1'b0;
            hold_char_r <= 9'h000;
            hold_cmd_r  <= 1'b0;
            brk_pend_r  <= 1'b0;
            tx_st_r     <= TX_IDLE;
            tx_load     <= 1'b0;
            tx_char     <= 9'h000;
            tx_cmd_sync <= 1'b0;
            tx_break    <= 1'b0;
        end
        else if (clk_en)
        begin
            tx_load <= 1'b0;
            if (wr_thr && tx_en_r)
            begin
                hold_full_r <= 1'b1;
                hold_char_r <= bus.wdata[8:0];
                hold_cmd_r  <= bus.wdata[B_SYNC];
            end
            // Break is queued behind the character in the shifter
            if (cmd(C_START_BREAK_CMD) && tx_en_r)
                brk_pend_r <= 1'b1;
            case (tx_st_r)
                TX_IDLE:
                begin
                    if (brk_pend_r)
                    begin
                        brk_pend_r <= 1'b0;
                        tx_break   <= 1'b1;
                        tx_st_r    <= TX_BREAK;
                    end
                    // Wait out a landing write, or the new character is lost
                    else if (hold_full_r && !wr_thr)
                    begin
                        hold_full_r <= 1'b0;
                        tx_load     <= 1'b1;
                        tx_char     <= hold_char_r;
                        tx_cmd_sync <= hold_cmd_r;
                        tx_st_r     <= TX_SHIFT;
                    end
                end
                TX_SHIFT:
                    if (tx_shift_done)
                        tx_st_r <= TX_IDLE;
                TX_BREAK:
                    if (cmd(C_STPBRK))
                    begin
                        tx_break <= 1'b0;
                        tx_st_r  <= TX_IDLE;
                    end
                default:
                    tx_st_r <= TX_IDLE;
            endcase
            // Disabling drops a waiting character and any queued break
            if (cmd(C_TXDIS))
            begin
                hold_full_r <= 1'b0;
                brk_pend_r  <= 1'b0;
            end
        end
    end

    // Sticky receive errors; a new event wins over the clear
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            brk_r <= 1'b0;
            ovr_r <= 1'b0;
            frm_r <= 1'b0;
            par_r <= 1'b0;
            retry_limit_hit_r <= 1'b0;
            man_r <= 1'b0;
        end
        else if (clk_en)
        begin
            brk_r  <= sticky(rx_ev.brk, brk_r, rst_sta);
            ovr_r  <= sticky(rx_ev.overrun, ovr_r, rst_sta);
            frm_r  <= sticky(rx_ev.frame, frm_r, rst_sta);
            par_r  <= sticky(rx_ev.parity, par_r, rst_sta);
            retry_limit_hit_r <= sticky(rx_ev.retry_limit_hit, retry_limit_hit_r, rst_sta);
            man_r  <= sticky(rx_ev.manchester_error_flag, man_r, rst_sta);
        end
    end

    // Time-out and negative ack have their own clears
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tmo_r  <= 1'b0;
            negative_ack_flag_r <= 1'b0;
        end
        else if (clk_en)
        begin
            // Status gates on the armed level, so a zero time-out reads 0
            tmo_r  <= sticky(rx_ev.timeout & timeout_armed, tmo_r,
                             cmd(C_START_TIMEOUT_CMD));
            negative_ack_flag_r <= sticky(rx_ev.negative_ack_flag, negative_ack_flag_r, cmd(C_RSTNAK));
        end
    end

    // Modem change detect, cleared by a status read
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            // Take the pin level so no false change follows reset
            mlvl_r <= modem_in;
            mchg_r <= 4'h0;
        end
        else if (clk_en)
        begin
            mlvl_r <= modem_in;
            mchg_r <= (modem_in ^ mlvl_r) | (mchg_r & {4{~rd_csr}});
        end
    end

    // Baud generator: divisor then sixteen-times oversampling
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            div_r <= DIV_RST;
            fp_r  <= 3'h0;
        end
        else if (clk_en && hit(bus.wr, OFF_BAUD))
        begin
            div_r <= bus.wdata[15:0];
            fp_r  <= bus.wdata[B_FP_LO+2:B_FP_LO];
        end
    end

    // Fraction is stored only; the tick ignores it. A zero divisor holds
    // the counters, so a new divisor starts with a full period.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            div_cnt_r <= '0;
            os_cnt_r  <= 4'h0;
            baud_tick <= 1'b0;
        end
        else if (clk_en)
        begin
            baud_tick <= 1'b0;
            if (div_r == DIV_RST)
            begin
                div_cnt_r <= '0;
                os_cnt_r  <= 4'h0;
            end
            else if (div_cnt_r >= DIV_W'(div_r - 16'h0001))
            begin
                div_cnt_r <= '0;
                os_cnt_r  <= os_cnt_r + 4'h1;
                baud_tick <= (os_cnt_r == 4'(OVERSAMPLE - 5'h01));
            end
            else
                div_cnt_r <= div_cnt_r + DIV_W'(1);
        end
    end

    always_comb
    begin
        // Channel flags pass straight through, modem levels one cycle late; only the flags are sticky
        status = ZERO32;
        status[B_RX_CHAR_READY]  = rx_char_ready_r;
        // A break in progress keeps the holding register closed as well
        status[B_TXFREE] = tx_en_r && !hold_full_r && !brk_pend_r &&
                           tx_st_r != TX_BREAK;
        status[B_BRK]    = brk_r;
        status[B_RX_DMA_END]  = dma.rx_end;
        status[B_TX_DMA_END]  = dma.tx_end;
        status[B_OVR]    = ovr_r;
        status[B_FRAME]  = frm_r;
        status[B_PAR]    = par_r;
        status[B_TMO]    = tmo_r && timeout_armed;
        status[B_TXEMP]  = tx_en_r && !hold_full_r &&
                           tx_st_r == TX_IDLE;
        status[B_RETRY_LIMIT_HIT]   = retry_limit_hit_r;
        status[B_TX_DMA_BUFFER_EMPTY] = dma.tx_buf_empty;
        status[B_RX_DMA_BUFFER_FULL] = dma.rx_buf_full;
        status[B_NEGATIVE_ACK_FLAG]   = negative_ack_flag_r;
        status[B_CTSC:B_RIC] = mchg_r;
        status[B_LVL+3:B_LVL] = mlvl_r;
        status[B_MANCHESTER_ERROR_FLAG] = man_r;
    end

    // Read data, one cycle after the strobe; mask bit 20 gates the manchester flag at 24
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rdata <= ZERO32;
            irq   <= 1'b0;
        end
        else if (clk_en)
        begin
            rdata <= ZERO32;
            if (bus.rd)
                case (bus.addr)
                    OFF_MASK_RB: rdata <= mask_r;
                    OFF_STATUS:  rdata <= status;
                    OFF_RX_HOLD: rdata <= {16'h0000, rx_cmd_r, 6'h00,
                                           rx_char_r};
                    OFF_BAUD:    rdata <= {13'h0000, fp_r, div_r};
                    // Write-only and unmapped offsets read as zero
                    default:     rdata <= ZERO32;
                endcase
            // Mask bit 20 gates the Manchester flag, not the line level
            irq <= |(status[19:0] & mask_r[19:0]) |
                   (status[B_MANCHESTER_ERROR_FLAG] & mask_r[B_MANMSK]);
        end
    end
endmodule : usr_regs
`default_nettype wire

// >>> bench/usr_regs_checker.sv
// Port-level checks on the serial port register block.
// Assumes no strobe while clk_en is low, as on the plain register port.
`timescale 1ns/100ps
`default_nettype none
module usr_regs_checker
    import usr_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              sys_rst,
    // Watched ports
    input wire usr_pkg::usr_bus_t bus,
    input wire logic [31:0]       rdata,
    input wire usr_pkg::usr_dma_t dma,
    input wire logic [3:0]        modem_in,
    input wire logic              tx_load,
    input wire logic              baud_tick,
    input wire logic              irq
);
    logic [31:0] mask_r;

    // Shadow of the mask, built only from bus writes
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            mask_r <= ZERO32;
        else if (bus.wr && bus.addr == OFF_MASK_EN)
            mask_r <= mask_r | (bus.wdata & MASK_VALID);
        else if (bus.wr && bus.addr == OFF_MASK_DIS)
            mask_r <= mask_r & ~bus.wdata;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    read_idle_a: assert property (
        !$past(bus.rd) |-> rdata == ZERO32)
        else $error("read data not idle");
    mask_read_a: assert property (
        bus.rd && bus.addr == OFF_MASK_RB |=> rdata == $past(mask_r))
        else $error("mask readback wrong");
    irq_quiet_a: assert property (
        mask_r == ZERO32 && $past(mask_r) == ZERO32 |-> !irq)
        else $error("irq with empty mask");
    dma_live_a: assert property (
        bus.rd && bus.addr == OFF_STATUS |=>
        rdata[4:3] == $past({dma.tx_end, dma.rx_end}) &&
        rdata[12:11] == $past({dma.rx_buf_full, dma.tx_buf_empty}))
        else $error("channel flags not live");
    modem_level_a: assert property (
        bus.rd && bus.addr == OFF_STATUS |=>
        rdata[23:20] == $past(modem_in, 2))
        else $error("modem levels wrong");
    rx_format_a: assert property (
        bus.rd && bus.addr == OFF_RX_HOLD |=>
        rdata[31:16] == 16'h0000 && rdata[14:9] == 6'h00)
        else $error("receive holding format wrong");
    load_pulse_a: assert property (
        tx_load |=> !tx_load)
        else $error("load longer than a cycle");
    tick_pulse_a: assert property (
        baud_tick |=> !baud_tick)
        else $error("baud tick too close");
endmodule : usr_regs_checker

bind usr_regs usr_regs_checker u_chk (
    .clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .dma(dma),
    .modem_in(modem_in), .tx_load(tx_load), .baud_tick(baud_tick),
    .irq(irq)
);
`default_nettype wire

// >>> bench/usr_peer.sv
// Far-side shifter model: reports each loaded character shifted out.
// Assumes one load at a time; DLY sets how slow the line is.
`timescale 1ns/100ps
`default_nettype none
module usr_peer #(
    parameter int DLY = 40
)(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Shifter handshake
    input wire logic tx_load,
    output logic     tx_shift_done
);
    int cnt_r;

    always_ff @(posedge clk)
    begin
        tx_shift_done <= 1'b0;
        if (sys_rst)
            cnt_r <= 0;
        else if (tx_load)
            cnt_r <= DLY;
        else if (cnt_r != 0)
        begin
            cnt_r <= cnt_r - 1;
            tx_shift_done <= (cnt_r == 1);
        end
    end
endmodule : usr_peer
`default_nettype wire

// >>> bench/usr_regs_test.sv
// Self-checking bench for the serial port register block.
// Assumes the far-side shifter model answers each load.
`timescale 1ns/100ps
`default_nettype none
module usr_regs_test;
    import usr_pkg::*;
    logic        clk, sys_rst, timeout_armed, tx_shift_done, tx_load;
    logic        tx_cmd_sync, tx_break, baud_tick, irq, clk_en;
    logic [3:0]  modem_in;
    logic [8:0]  tx_char;
    logic [31:0] rdata, v;
    usr_bus_t    bus;
    usr_rxev_t   rx_ev;
    usr_dma_t    dma;
    int          failures, comparisons, cyc;

    usr_regs dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus(bus),
        .rdata(rdata), .rx_ev(rx_ev), .dma(dma), .modem_in(modem_in),
        .timeout_armed(timeout_armed), .tx_shift_done(tx_shift_done),
        .tx_load(tx_load), .tx_char(tx_char), .tx_cmd_sync(tx_cmd_sync),
        .tx_break(tx_break), .baud_tick(baud_tick), .irq(irq));
    usr_peer #(.DLY(40)) peer (.clk(clk), .sys_rst(sys_rst),
        .tx_load(tx_load), .tx_shift_done(tx_shift_done));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus <= '{a, ZERO32, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic st(input int b, input logic e);
        rd(OFF_STATUS, v);
        chk({31'h0, v[b]}, {31'h0, e});
    endtask : st
    task automatic pulse(input usr_rxev_t e);
        @(posedge clk);
        rx_ev <= e;
        @(posedge clk);
        rx_ev <= '0;
    endtask : pulse
    task automatic wait_hi(input logic d);
        int n;
        n = 0;
        while ((d ? tx_shift_done : tx_load) !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({31'h0, d ? tx_shift_done : tx_load}, 32'h1);
    endtask : wait_hi
    task automatic gap(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (baud_tick !== 1'b1 && n < 200);
    endtask : gap

    task automatic t_mask;
        wr(OFF_MASK_EN, 32'hffff_ffff);
        wr(OFF_MASK_DIS, 32'h0000_0003);
        wr(OFF_MASK_EN, ZERO32);
        rd(OFF_MASK_RB, v);
        chk(v, MASK_VALID & 32'hffff_fffc);
        rd(8'hfc, v);
        chk(v, ZERO32);
    endtask : t_mask
    task automatic t_sticky;
        int sh [7] = '{7, 6, 5, 4, 2, 0, 1};
        int pos [7] = '{2, 5, 6, 7, 10, 24, 13};
        for (int k = 0; k < 7; k++)
        begin
            pulse(usr_rxev_t'(19'h1 << sh[k]));
            st(pos[k], 1'b1);
            chk({31'h0, irq}, 32'h1);
            wr(OFF_CTRL, 32'h1 << C_CLEAR_STATUS_CMD);
            st(pos[k], k == 6);
        end
        wr(OFF_CTRL, 32'h1 << C_RSTNAK);
        st(13, 1'b0);
        chk({31'h0, irq}, ZERO32);
    endtask : t_sticky
    task automatic t_hold;
        @(posedge clk);
        clk_en <= 1'b0;
        pulse(usr_rxev_t'(19'h40));
        @(posedge clk);
        clk_en <= 1'b1;
        st(5, 1'b0);
    endtask : t_hold
    task automatic t_tmo;
        @(posedge clk);
        timeout_armed <= 1'b1;
        pulse(usr_rxev_t'(19'h8));
        st(8, 1'b1);
        wr(OFF_CTRL, 32'h1 << C_START_TIMEOUT_CMD);
        st(8, 1'b0);
        @(posedge clk);
        timeout_armed <= 1'b0;
        pulse(usr_rxev_t'(19'h8));
        st(8, 1'b0);
        @(posedge clk);
        timeout_armed <= 1'b1;
        st(8, 1'b0);
        pulse(usr_rxev_t'(19'h8));
        @(posedge clk);
        timeout_armed <= 1'b0;
        st(8, 1'b0);
    endtask : t_tmo
    task automatic t_rx;
        wr(OFF_CTRL, 32'h1 << C_RXEN);
        pulse(usr_rxev_t'({1'b1, 9'h1a5, 1'b1, 8'h00}));
        st(0, 1'b1);
        rd(OFF_RX_HOLD, v);
        chk(v, 32'h0000_81a5);
        st(0, 1'b0);
        pulse(usr_rxev_t'({1'b1, 9'h05a, 1'b0, 8'h00}));
        wr(OFF_CTRL, 32'h1 << C_RXDIS);
        st(0, 1'b0);
        wr(OFF_CTRL, 32'h1 << C_RXEN);
        st(0, 1'b1);
        rd(OFF_RX_HOLD, v);
        chk(v, 32'h0000_005a);
    endtask : t_rx
    task automatic t_tx;
        st(1, 1'b0);
        wr(OFF_CTRL, 32'h1 << C_TXEN);
        st(1, 1'b1);
        st(9, 1'b1);
        wr(OFF_TX_HOLD, 32'h0000_8123);
        wait_hi(1'b0);
        chk({22'h0, tx_cmd_sync, tx_char}, 32'h0000_0323);
        // Second char lands while the first is still shifting
        wr(OFF_TX_HOLD, 32'h0000_0045);
        st(1, 1'b0);
        st(9, 1'b0);
        wait_hi(1'b0);
        chk({22'h0, tx_cmd_sync, tx_char}, 32'h0000_0045);
        wait_hi(1'b1);
        st(1, 1'b1);
        st(9, 1'b1);
        wr(OFF_CTRL, 32'h1 << C_START_BREAK_CMD);
        st(1, 1'b0);
        chk({31'h0, tx_break}, 32'h1);
        wr(OFF_CTRL, 32'h1 << C_STPBRK);
        wr(OFF_CTRL, 32'h1 << C_TXDIS);
        st(9, 1'b0);
        chk({31'h0, tx_break}, ZERO32);
    endtask : t_tx
    task automatic t_line;
        @(posedge clk);
        modem_in <= 4'h9;
        dma <= '1;
        repeat (2) @(posedge clk);
        rd(OFF_STATUS, v);
        chk(v & 32'h00ff_1818, 32'h0099_1818);
        rd(OFF_STATUS, v);
        chk(v & 32'h00ff_0000, 32'h0090_0000);
        @(posedge clk);
        dma <= '0;
        rd(OFF_STATUS, v);
        chk(v & 32'h0000_1818, ZERO32);
    endtask : t_line
    task automatic t_baud;
        int n;
        wr(OFF_BAUD, 32'h0005_0003);
        rd(OFF_BAUD, v);
        chk(v, 32'h0005_0003);
        gap(n);
        gap(n);
        chk(n, 32'd48);
        wr(OFF_BAUD, ZERO32);
        gap(n);
        gap(n);
        chk(n, 32'd200);
    endtask : t_baud

    task automatic wrap_up;
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Whole run needs under a thousand cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            wrap_up();
        end
    end
    initial
    begin
        sys_rst = 1'b1;
        bus = '0;
        rx_ev = '0;
        dma = '0;
        modem_in = 4'h0;
        timeout_armed = 1'b0;
        clk_en = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_mask();
        t_sticky();
        t_hold();
        t_tmo();
        t_rx();
        t_tx();
        t_line();
        t_baud();
        wrap_up();
    end
endmodule : usr_regs_test
`default_nettype wire
